// ===== design/dcf_pkg.sv
// ---------------------------------------------------------------
// Shared constants of the flag and read logic.
// ---------------------------------------------------------------
package dcf_pkg;
  // Data width of a FIFO word.
  localparam int DATA_W = 36;
  // Memory index width and pointer width (one wrap bit more).
  localparam int ADDR_W = 11;
  localparam int PTR_W = 12;
  // Memory depth in words, as a count and as a pointer value.
  localparam int DEPTH_N = 2048;
  localparam logic [PTR_W-1:0] DEPTH = 12'h800;
  // Reset value of both flag offset registers.
  localparam logic [ADDR_W-1:0] OFS_RST = 11'h040;
  // Register map, byte addresses.
  localparam int AXI_AW = 8;
  localparam logic [AXI_AW-1:0] REG_CTRL = 8'h00;
  localparam logic [AXI_AW-1:0] REG_AEOFS = 8'h04;
  localparam logic [AXI_AW-1:0] REG_AFOFS = 8'h08;
  localparam logic [AXI_AW-1:0] REG_STATUS = 8'h0C;
  localparam logic [AXI_AW-1:0] REG_WCOUNT = 8'h10;
  localparam logic [AXI_AW-1:0] REG_RCOUNT = 8'h14;
  // Field positions.
  localparam int CTRL_FALL_THROUGH_MODE = 0;
  localparam int ST_READY = 0;
  localparam int ST_AEMPTY = 1;
  localparam int ST_AFULL = 2;
  localparam int ST_INREADY = 3;
  // Bus responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Binary to Gray conversion.
  function automatic logic [PTR_W-1:0] bin2gray(logic [PTR_W-1:0] b);
    return b ^ (b >> 1);
  endfunction

  // Gray to binary conversion.
  function automatic logic [PTR_W-1:0] gray2bin(logic [PTR_W-1:0] g);
    logic [PTR_W-1:0] b;
    b = g;
    for (int i = PTR_W - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction
endpackage

// ===== design/dcf_flag_read.sv
// What this block does
// RQ1 - Read loads output register only when enabled
// RQ2 - Reads proceed independently of concurrent writes
// RQ3 - Fall-through: next word loads as ready rises
// RQ4 - Fall-through, ready high: load only on read
// RQ5 - Standard mode: load only on enabled read
// RQ6 - Flags pass two or more sync stages
// RQ7 - Read-side flags; read pointer advances per load
// RQ8 - Fall-through flag means fresh output data
// RQ9 - Standard flag means memory holds readable data
// RQ10 - Fall-through word appears third read edge
// RQ11 - Standard flag rises second read edge
// RQ12 - Early read edge not first sync cycle
// RQ13 - Writes ignored while input-ready low
// RQ14 - Write-side full flag; pointer steps per write
// RQ15 - Input-ready rises second write edge after read
// RQ16 - Early write edge not first sync cycle
// RQ17 - Empty memory: both read flags low
// RQ18 - Almost-full and full thresholds from count
// RQ19 - Output register word not counted
// RQ20 - Fallen-through word frees its location
// RQ21 - Write occurs only when enabled and ready
// RQ22 - Thresholds derive from depth and offsets
//
// The register addresses and the AXI4-Lite slave port were decided locally.
`timescale 1ns/100ps
module dcf_flag_read
  import dcf_pkg::*;
(
  // Clock and synchronous active-low reset.
  input wire logic clk,
  input wire logic rstn,
  // Write port; writeTick marks one write clock edge.
  input wire logic writeTick,
  input wire logic writePortSelectN,
  input wire logic writePortDirection,
  input wire logic writePortEnable,
  input wire logic writePortMailboxSelect,
  input wire logic [DATA_W-1:0] writeData,
  output logic fullOrInputReadyFlag,
  output logic almostFullFlag,
  // Read port; readTick marks one read clock edge.
  input wire logic readTick,
  input wire logic readPortSelectN,
  input wire logic readPortDirection,
  input wire logic readPortEnable,
  input wire logic readPortMailboxSelect,
  output logic [DATA_W-1:0] readData,
  output logic emptyOrOutputReadyFlag,
  output logic almostEmptyFlag,
  // AXI4-Lite register slave.
  input wire logic [AXI_AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [AXI_AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Byte-lane merge of a register write.
  function automatic logic [31:0] mergeBytes(logic [31:0] old,
    logic [31:0] nw, logic [3:0] strb);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        m[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return m;
  endfunction

  // True for an address that holds a register.
  function automatic logic regMapped(logic [AXI_AW-1:0] a);
    return a == REG_CTRL || a == REG_AEOFS || a == REG_AFOFS ||
      a == REG_STATUS || a == REG_WCOUNT || a == REG_RCOUNT;
  endfunction

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] mem [DEPTH_N]; // Word storage, no reset.
  logic fallThrough_r; // Mode: 1 is first-word-fall-through.
  logic [ADDR_W-1:0] aeOffset_r; // Almost-empty offset.
  logic [ADDR_W-1:0] afOffset_r; // Almost-full offset.
  // Write side.
  logic [PTR_W-1:0] wrPtr_r, wrGray_r, wrPtr_nxt, wrCount_nxt;
  logic [PTR_W-1:0] rdSync1_r, rdSync2_r, rdPipe_r;
  logic writeAccept, fullFlag_r, almostFullFlag_r;
  // Read side.
  logic [PTR_W-1:0] rdPtr_r, rdGray_r, rdPtr_nxt, rdCount_nxt;
  logic [PTR_W-1:0] wrSync1_r, wrSync2_r, wrPipeA_r, wrPipeB_r;
  logic readSel, loadOut, readyFlag_r, readyFlag_nxt;
  logic almostEmptyFlag_r;
  logic [DATA_W-1:0] outData_r;
  // Bus slave.
  logic awHeld_r, wHeld_r, regWrite;
  logic [AXI_AW-1:0] awAddr_r;
  logic [31:0] wData_r, readWord, rdata_r;
  logic [3:0] wStrb_r;
  logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic [1:0] bresp_r, rresp_r;
  // Held write data merged byte by byte into each control register.
  logic [31:0] ctrlMrg, aeMrg, afMrg;

  // ---------------------------------------------------------------
  // Write side
  // ---------------------------------------------------------------
  // A write needs the full port decode and a free location.
  always_comb begin
    writeAccept = writeTick && !writePortSelectN && writePortDirection &&
      writePortEnable && !writePortMailboxSelect &&
      fullFlag_r; // [RQ21] [RQ13]
    wrPtr_nxt = writeAccept ? wrPtr_r + 12'h001 : wrPtr_r; // [RQ14]
    // Own writes count at once, reads only after synchronising.
    wrCount_nxt = wrPtr_nxt - rdPipe_r;
  end

  // Write pointer, binary and Gray copy for the crossing.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      wrPtr_r <= 12'h000;
      wrGray_r <= 12'h000;
    end else begin
      wrPtr_r <= wrPtr_nxt;
      wrGray_r <= bin2gray(wrPtr_nxt);
    end
  end

  // Memory write.
  always_ff @(posedge clk) begin
    if (writeAccept) begin
      mem[wrPtr_r[ADDR_W-1:0]] <= writeData;
    end
  end

  // Read pointer into the write side: two flops every clock, then a
  // stage taken at a write edge, so the flags see a read only at the
  // second write edge after it.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rdSync1_r <= 12'h000;
      rdSync2_r <= 12'h000;
      rdPipe_r <= 12'h000;
    end else begin
      rdSync1_r <= rdGray_r; // [RQ6]
      rdSync2_r <= rdSync1_r; // [RQ6]
      if (writeTick) begin
        rdPipe_r <= gray2bin(rdSync2_r); // [RQ16]
      end
    end
  end

  // Write-side flags, updated at write edges only.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      fullFlag_r <= 1'b1;
      almostFullFlag_r <= 1'b1;
    end else if (writeTick) begin
      fullFlag_r <= wrCount_nxt != DEPTH; // [RQ14] [RQ15] [RQ18]
      almostFullFlag_r <= wrCount_nxt <
        (DEPTH - {1'b0, afOffset_r}); // [RQ18] [RQ22]
    end
  end

  // ---------------------------------------------------------------
  // Read side
  // ---------------------------------------------------------------
  // The read decode looks at no write-side term at all.
  always_comb begin
    readSel = readTick && !readPortSelectN && readPortDirection &&
      readPortEnable && !readPortMailboxSelect; // [RQ1] [RQ2]
    readyFlag_nxt = readyFlag_r;
    if (fallThrough_r) begin
      // Refill when the register is stale or being consumed.
      loadOut = readTick && (!readyFlag_r || readSel) &&
        (wrPipeB_r != rdPtr_r); // [RQ3] [RQ4] [RQ10]
      if (readTick && (!readyFlag_r || readSel)) begin
        readyFlag_nxt = wrPipeB_r != rdPtr_r; // [RQ8]
      end
    end else begin
      loadOut = readSel && readyFlag_r; // [RQ5] [RQ9]
    end
    rdPtr_nxt = loadOut ? rdPtr_r + 12'h001 : rdPtr_r; // [RQ7] [RQ20]
    // The word in the output register is already out of memory.
    rdCount_nxt = wrPipeA_r - rdPtr_nxt; // [RQ19]
    if (!fallThrough_r && readTick) begin
      readyFlag_nxt = rdCount_nxt != 12'h000; // [RQ9] [RQ11]
    end
  end

  // Read pointer, binary and Gray copy for the crossing.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rdPtr_r <= 12'h000;
      rdGray_r <= 12'h000;
    end else begin
      rdPtr_r <= rdPtr_nxt;
      rdGray_r <= bin2gray(rdPtr_nxt);
    end
  end

  // Write pointer into the read side. Stage A feeds the standard
  // flag and almost-empty (second edge); stage B feeds fall-through
  // (third edge). An edge too close to a write sees the old value.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      wrSync1_r <= 12'h000;
      wrSync2_r <= 12'h000;
      wrPipeA_r <= 12'h000;
      wrPipeB_r <= 12'h000;
    end else begin
      wrSync1_r <= wrGray_r; // [RQ6]
      wrSync2_r <= wrSync1_r; // [RQ6]
      if (readTick) begin
        wrPipeA_r <= gray2bin(wrSync2_r); // [RQ12]
        wrPipeB_r <= wrPipeA_r; // [RQ10]
      end
    end
  end

  // Read-side flags, updated at read edges only.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      readyFlag_r <= 1'b0;
      almostEmptyFlag_r <= 1'b0;
    end else if (readTick) begin
      readyFlag_r <= readyFlag_nxt; // [RQ7]
      almostEmptyFlag_r <= rdCount_nxt >
        {1'b0, aeOffset_r}; // [RQ17] [RQ22]
    end
  end

  // Output register keeps the previous word unless loaded.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      outData_r <= '0;
    end else if (loadOut) begin
      outData_r <= mem[rdPtr_r[ADDR_W-1:0]]; // [RQ1]
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------
  assign regWrite = awHeld_r && wHeld_r;

  // Address and data are taken in either order; the response waits
  // for both, and ready stays low until the response is taken.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      awAddr_r <= '0;
      wData_r <= 32'h0000_0000;
      wStrb_r <= 4'h0;
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else begin
      if (awvalid && awready_r) begin
        awAddr_r <= awaddr;
        awHeld_r <= 1'b1;
        awready_r <= 1'b0;
      end
      if (wvalid && wready_r) begin
        wData_r <= wdata;
        wStrb_r <= wstrb;
        wHeld_r <= 1'b1;
        wready_r <= 1'b0;
      end
      if (regWrite) begin
        awHeld_r <= 1'b0;
        wHeld_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= regMapped(awAddr_r) ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid_r && bready) begin
        bvalid_r <= 1'b0;
        awready_r <= 1'b1;
        wready_r <= 1'b1;
      end
    end
  end

  // Merged words are formed apart, since a call's result is not indexed.
  always_comb begin
    ctrlMrg = mergeBytes({31'h0, fallThrough_r}, wData_r, wStrb_r);
    aeMrg = mergeBytes({21'h0, aeOffset_r}, wData_r, wStrb_r);
    afMrg = mergeBytes({21'h0, afOffset_r}, wData_r, wStrb_r);
  end

  // Control registers. Mode is meant to stay static while data flows.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      fallThrough_r <= 1'b0;
      aeOffset_r <= OFS_RST;
      afOffset_r <= OFS_RST;
    end else if (regWrite) begin
      case (awAddr_r)
        REG_CTRL: fallThrough_r <= ctrlMrg[CTRL_FALL_THROUGH_MODE];
        REG_AEOFS: aeOffset_r <= aeMrg[ADDR_W-1:0];
        REG_AFOFS: afOffset_r <= afMrg[ADDR_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // Read decode; unmapped addresses read zero.
  always_comb begin
    readWord = 32'h0000_0000;
    case (araddr)
      REG_CTRL: readWord[CTRL_FALL_THROUGH_MODE] = fallThrough_r;
      REG_AEOFS: readWord[ADDR_W-1:0] = aeOffset_r;
      REG_AFOFS: readWord[ADDR_W-1:0] = afOffset_r;
      REG_STATUS: begin
        readWord[ST_READY] = readyFlag_r;
        readWord[ST_AEMPTY] = almostEmptyFlag_r;
        readWord[ST_AFULL] = almostFullFlag_r;
        readWord[ST_INREADY] = fullFlag_r;
      end
      REG_WCOUNT: readWord[PTR_W-1:0] = wrPtr_r - rdPipe_r;
      REG_RCOUNT: readWord[PTR_W-1:0] = wrPipeA_r - rdPtr_r;
      default: readWord = 32'h0000_0000;
    endcase
  end

  // Read channel: one read at a time.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= RESP_OKAY;
    end else if (arvalid && arready_r) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rdata_r <= readWord;
      rresp_r <= regMapped(araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_r && rready) begin
      rvalid_r <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  // Outputs, each straight from a flop.
  assign fullOrInputReadyFlag = fullFlag_r;
  assign almostFullFlag = almostFullFlag_r;
  assign readData = outData_r;
  assign emptyOrOutputReadyFlag = readyFlag_r;
  assign almostEmptyFlag = almostEmptyFlag_r;
  assign awready = awready_r;
  assign wready = wready_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign arready = arready_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_fwftStale;
    fallThrough_r && readTick && !readyFlag_r;
  endsequence
  sequence s_fwftLoaded;
    readyFlag_r && (rdPtr_r == $past(rdPtr_r) + 12'h001);
  endsequence

  a_write_ignored: assert property ((writeTick && !fullFlag_r) |=> // [RQ13]
    wrPtr_r == $past(wrPtr_r))
    else $error("write taken while input-ready low");
  a_sync_depth: assert property (##2 wrSync2_r == $past(wrGray_r, 2)) // [RQ6]
    else $error("write pointer sync is not two stages");
  a_full_implies: assert property (!fullFlag_r |-> !almostFullFlag_r) // [RQ18]
    else $error("full without almost-full");
  a_empty_flags: assert property ((!fallThrough_r && !readyFlag_r // [RQ17]
    && $stable(fallThrough_r)) |-> !almostEmptyFlag_r)
    else $error("almost-empty high with empty memory");
  a_ready_edge: assert property ($rose(readyFlag_r) |-> // [RQ11]
    $past(readTick))
    else $error("read flag rose off a read edge");
  a_inready_edge: assert property ($rose(fullFlag_r) |-> // [RQ15]
    $past(writeTick))
    else $error("input-ready rose off a write edge");
  a_fall_through_mode_load: assert property ((s_fwftStale and // [RQ3]
    (wrPipeB_r != rdPtr_r)) |=> s_fwftLoaded)
    else $error("fall-through word not loaded");
  a_out_hold: assert property ((readyFlag_r && !readSel && // [RQ4]
    $stable(fallThrough_r)) |=> $stable(outData_r))
    else $error("output register changed without a read");
  a_std_read: assert property ((!fallThrough_r && readSel && // [RQ5]
    readyFlag_r) |=> rdPtr_r == $past(rdPtr_r) + 12'h001)
    else $error("standard read did not advance pointer");
endmodule

// ===== test/dcf_host_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// Host logic that drives both FIFO ports.
// ----------------------------------------
module dcf_host_model
  import dcf_pkg::*;
(
  // Clock, reset and bench commands.
  input wire logic clk,
  input wire logic rstn,
  input wire logic cmdWr,
  input wire logic cmdRd,
  input wire logic cmdMb,
  input wire logic [DATA_W-1:0] cmdData,
  output logic slot,
  // Write port.
  output logic writeTick,
  output logic writePortSelectN,
  output logic writePortDirection,
  output logic writePortEnable,
  output logic writePortMailboxSelect,
  output logic [DATA_W-1:0] writeData,
  // Read port.
  output logic readTick,
  output logic readPortSelectN,
  output logic readPortDirection,
  output logic readPortEnable,
  output logic readPortMailboxSelect
);
  logic [1:0] phase_r; // Position within the three-cycle port period.

  // The cycle before each tick, when the controls are set up.
  assign slot = (phase_r == 2'h2);

  // Directions never change; every other pin settles at the first
  // clock edge of reset, so each has a single driver.
  initial begin
    {writePortDirection, readPortDirection} = 2'h3;
  end

  // Both port clocks tick together every third cycle, which keeps the
  // skew spacing so that edge counts are exact.
  always @(posedge clk) begin
    phase_r <= (!rstn || slot) ? 2'h0 : phase_r + 2'h1;
    writeTick <= rstn && slot;
    readTick <= rstn && slot;
    writePortEnable <= rstn && slot && cmdWr;
    writePortSelectN <= !(slot && cmdWr);
    writePortMailboxSelect <= slot && cmdWr && cmdMb;
    readPortEnable <= rstn && slot && cmdRd;
    readPortSelectN <= !(slot && cmdRd);
    readPortMailboxSelect <= slot && cmdRd && cmdMb;
    // Idle data flips so a stale word cannot pass for a fresh one.
    writeData <= !rstn ? '0 : (slot && cmdWr) ? cmdData : ~writeData;
  end
endmodule

// ===== test/dcf_flag_read_bench.sv
`timescale 1ns/100ps
// ----------------------------------------
// Self-checking bench of the flag and read logic.
// ----------------------------------------
module dcf_flag_read_bench import dcf_pkg::*;;
  logic clk, rstn, cmdWr, cmdRd, cmdMb, slot;
  logic [DATA_W-1:0] cmdData, writeData, readData;
  logic writeTick, writePortSelectN, writePortDirection, writePortEnable;
  logic writePortMailboxSelect, readTick, readPortSelectN;
  logic readPortDirection, readPortEnable, readPortMailboxSelect;
  logic fullOrInputReadyFlag, almostFullFlag;
  logic emptyOrOutputReadyFlag, almostEmptyFlag;
  logic [AXI_AW-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  int nMismatch = 0;
  int compares = 0;
  int cycles = 0;

  dcf_host_model i_host (.clk, .rstn, .cmdWr, .cmdRd, .cmdMb, .cmdData,
    .slot, .writeTick, .writePortSelectN, .writePortDirection,
    .writePortEnable, .writePortMailboxSelect, .writeData, .readTick,
    .readPortSelectN, .readPortDirection, .readPortEnable,
    .readPortMailboxSelect);

  dcf_flag_read i_dut (.clk, .rstn, .writeTick, .writePortSelectN,
    .writePortDirection, .writePortEnable, .writePortMailboxSelect,
    .writeData, .fullOrInputReadyFlag, .almostFullFlag, .readTick,
    .readPortSelectN, .readPortDirection, .readPortEnable,
    .readPortMailboxSelect, .readData, .emptyOrOutputReadyFlag,
    .almostEmptyFlag, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready);

  // ----------------------------------------
  // Clock and hang guard.
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // The longest scenario fills and drains the whole memory once.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      nMismatch++;
      finishTest();
    end
  end

  // ----------------------------------------
  // Shared tasks.
  // ----------------------------------------
  task automatic check(input string what, input logic [35:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      nMismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One port period: requests ride on the next tick, then flags settle.
  task automatic port(input logic w, r, m, input logic [DATA_W-1:0] d);
    cmdWr <= w;
    cmdRd <= r;
    cmdMb <= m;
    cmdData <= d;
    @(posedge clk);
    while (!slot) @(posedge clk);
    {cmdWr, cmdRd, cmdMb} <= 3'h0;
    @(posedge clk);
    #1;
  endtask

  // Address and data are offered together and dropped once taken.
  task automatic axiWr(input logic [AXI_AW-1:0] a, input logic [31:0] d);
    @(posedge clk);
    {awaddr, wdata} <= {a, d};
    {awvalid, wvalid, bready} <= 3'h7;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    check("bresp", 36'(bresp), 36'(RESP_OKAY));
  endtask

  task automatic axiRd(input logic [AXI_AW-1:0] a);
    @(posedge clk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    {rd, rr} = {rdata, rresp};
  endtask

  // ----------------------------------------
  // Scenarios.
  // ----------------------------------------
  task automatic tReset;
    check("in ready", fullOrInputReadyFlag, 1'b1);
    check("almost full", almostFullFlag, 1'b1);
    check("ready", emptyOrOutputReadyFlag, 1'b0);
    check("almost empty", almostEmptyFlag, 1'b0);
    axiRd(REG_AEOFS);
    check("empty offset", 36'(rd), 36'(OFS_RST));
    axiRd(8'h20);
    check("unmapped resp", 36'(rr), 36'(RESP_SLVERR));
    check("unmapped data", 36'(rd), 36'h0);
  endtask

  task automatic tStd;
    port(0, 1, 0, '0);
    check("empty read", readData, 36'h0);
    port(1, 0, 0, 36'h9_AAAA_5555);
    check("flag at write", emptyOrOutputReadyFlag, 1'b0);
    port(0, 0, 0, '0);
    check("flag one sync", emptyOrOutputReadyFlag, 1'b0);
    port(0, 0, 0, '0);
    check("flag two sync", emptyOrOutputReadyFlag, 1'b1);
    check("no load", readData, 36'h0);
    port(0, 1, 1, '0);
    check("mailbox read", readData, 36'h0);
    port(0, 1, 0, '0);
    check("read word", readData, 36'h9_AAAA_5555);
    check("empty again", emptyOrOutputReadyFlag, 1'b0);
    port(1, 0, 1, 36'h1);
    port(0, 0, 0, '0);
    port(0, 0, 0, '0);
    check("mailbox write", emptyOrOutputReadyFlag, 1'b0);
  endtask

  task automatic tAempty;
    axiWr(REG_AEOFS, 32'h2);
    port(1, 0, 0, 36'h1);
    port(1, 0, 0, 36'h2);
    port(0, 0, 0, '0);
    port(0, 0, 0, '0);
    check("two words", almostEmptyFlag, 1'b0);
    port(1, 0, 0, 36'h3);
    port(0, 0, 0, '0);
    port(0, 0, 0, '0);
    check("three words", almostEmptyFlag, 1'b1);
    for (int i = 1; i <= 3; i++) begin
      port(0, 1, 0, '0);
      check("word order", readData, 36'(i));
    end
    check("drained", emptyOrOutputReadyFlag, 1'b0);
    check("drained ae", almostEmptyFlag, 1'b0);
  endtask

  task automatic tFull;
    int y;
    y = int'(OFS_RST);
    for (int i = 0; i < DEPTH_N; i++) begin
      port(1, 0, 0, 36'(i));
      if (i == DEPTH_N - y - 2)
        check("below af", almostFullFlag, 1'b1);
      if (i == DEPTH_N - y - 1)
        check("at af", almostFullFlag, 1'b0);
      if (i == DEPTH_N - 2)
        check("one free", fullOrInputReadyFlag, 1'b1);
    end
    check("full", fullOrInputReadyFlag, 1'b0);
    axiRd(REG_STATUS);
    check("status", 36'(rd), 36'((1 << ST_READY) | (1 << ST_AEMPTY)));
    axiRd(REG_WCOUNT);
    check("write count", 36'(rd), 36'(DEPTH_N));
    port(1, 0, 0, 36'hF_FFFF_FFFF);
    check("refused", fullOrInputReadyFlag, 1'b0);
    port(0, 1, 0, '0);
    check("first out", readData, 36'h0);
    port(0, 0, 0, '0);
    check("ir one sync", fullOrInputReadyFlag, 1'b0);
    port(0, 0, 0, '0);
    check("ir two sync", fullOrInputReadyFlag, 1'b1);
    for (int i = 1; i < DEPTH_N; i++) begin
      port(0, 1, 0, '0);
      check("drain", readData, 36'(i));
    end
    check("emptied", emptyOrOutputReadyFlag, 1'b0);
  endtask

  task automatic tFwft;
    axiWr(REG_CTRL, 32'h1);
    port(1, 0, 0, 36'hA_1234_5678);
    port(1, 0, 0, 36'hB_8765_4321);
    port(0, 0, 0, '0);
    check("two sync", emptyOrOutputReadyFlag, 1'b0);
    check("old word", readData, 36'(DEPTH_N - 1));
    port(0, 0, 0, '0);
    check("fell through", emptyOrOutputReadyFlag, 1'b1);
    check("first word", readData, 36'hA_1234_5678);
    port(0, 0, 0, '0);
    check("held", readData, 36'hA_1234_5678);
    port(0, 1, 0, '0);
    check("next word", readData, 36'hB_8765_4321);
    check("still ready", emptyOrOutputReadyFlag, 1'b1);
    port(0, 1, 0, '0);
    check("not ready", emptyOrOutputReadyFlag, 1'b0);
    check("kept", readData, 36'hB_8765_4321);
  endtask

  task automatic finishTest;
    $display("compares %0d mismatches %0d", compares, nMismatch);
    if (nMismatch == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence.
  // ----------------------------------------
  initial begin
    rstn = 1'b0;
    {cmdWr, cmdRd, cmdMb, cmdData} = '0;
    {awaddr, awvalid, wdata, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
    wstrb = 4'hF;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    #1;
    tReset();
    tStd();
    tAempty();
    tFull();
    tFwft();
    finishTest();
  end
endmodule
